// ### logic/tls_defs.vh
// Constants for the thermal link status and timing block
// Assumes inclusion by bare name from the design files
`ifndef TLS_DEFS_VH
`define TLS_DEFS_VH
// Register byte offsets
`define TLS_OFF_CTRL 8'h08
`define TLS_OFF_STAT1 8'h0C
`define TLS_OFF_STAT2 8'h10
`define TLS_OFF_ERR 8'h14
`define TLS_OFF_IEN1 8'h18
`define TLS_OFF_IEN2 8'h1C
`define TLS_OFF_BT_LO 8'h20
`define TLS_OFF_BT_HI 8'h24
`define TLS_OFF_DIV 8'h30
`define TLS_OFF_ID 8'h40
`define TLS_OFF_REV 8'h44
// Control fields
`define TLS_CTRL_SUMMARY_IRQ_ENABLE 7
`define TLS_CTRL_GO 6
`define TLS_CTRL_SRST 3
// Status one fields
`define TLS_ST1_SUM 7
`define TLS_ST1_ERR 2
`define TLS_ST1_EOF 1
`define TLS_ST1_BOF 0
// Status two fields
`define TLS_ST2_IDLE 7
`define TLS_ST2_RFE 3
`define TLS_ST2_RFF 2
`define TLS_ST2_WFE 1
`define TLS_ST2_WFF 0
// Error fields
`define TLS_ERR_READY 7
`define TLS_ERR_RX_OVERRUN_ERROR 6
`define TLS_ERR_TX_UNDERRUN_ERROR 5
`define TLS_ERR_TX_OVERRUN_ERROR 4
`define TLS_ERR_CONT 1
`define TLS_ERR_FCS 0
`define TLS_ERR_MASK 8'hF3
// Enable fields
`define TLS_IEN1_ERR 2
`define TLS_IEN1_EOF 1
`define TLS_IEN1_BOF 0
`define TLS_IEN2_RFF 2
`define TLS_IEN2_WFE 1
`define TLS_IEN1_MASK 8'h07
`define TLS_IEN2_MASK 8'h06
// Reset values
`define TLS_BT_LO_RST 8'h16
`define TLS_BT_HI_RST 8'h00
`define TLS_DIV_RST 4'h1
// Identification values are arbitrary
`define TLS_ID_VAL 32'h00005A01
`define TLS_REV_VAL 32'h00000001
`endif

// ### logic/tls_clk_div.v
// Divider making the link core clock enable from the system clock
// Assumes one clock and a synchronous active-low clear
`timescale 1ns/1ps
`default_nettype none
module tls_clk_div (
  input wire clk_sys,
  input wire clr_n,
  input wire [3:0] div_val,
  output reg tick
);
  reg [3:0] cnt_ff;
  wire [3:0] lim;
  assign lim = (div_val == 4'h0) ? 4'h1 : div_val;
  always @(posedge clk_sys) begin
    if (!clr_n) begin
      cnt_ff <= 4'h1;
      tick <= 1'b0;
    end else if (cnt_ff >= lim) begin
      cnt_ff <= 4'h1;
      tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
      tick <= 1'b0;
    end
  end
endmodule // tls_clk_div
`default_nettype wire

// ### logic/tls_pulse_timer.v
// Timer holding a high pulse for a count of core clock ticks
// Assumes tick is a one-cycle enable from the divider
`timescale 1ns/1ps
`default_nettype none
module tls_pulse_timer (
  input wire clk_sys,
  input wire clr_n,
  input wire start,
  input wire tick,
  input wire [13:0] ticks,
  output reg busy
);
  reg [13:0] left_ff;
  always @(posedge clk_sys) begin
    if (!clr_n) begin
      left_ff <= 14'h0000;
      busy <= 1'b0;
    end else if (start && !busy) begin
      left_ff <= (ticks == 14'h0000) ? 14'h0001 : ticks;
      busy <= 1'b1;
    end else if (busy && tick) begin
      left_ff <= left_ff - 14'h0001;
      if (left_ff == 14'h0001) begin
        busy <= 1'b0;
      end
    end
  end
endmodule // tls_pulse_timer
`default_nettype wire

// ### logic/tls_link_status.v
// Status, error capture, enables and bit timing of the thermal link host
// Assumes the framing core reports events as one-cycle pulses on clk_sys
// Operation
// - Receive full flag, zero after reset
// - Transmit empty one, full zero, full no irq
// - Ready loss sets its error bit
// - Receive overrun sets its error bit
// - Transmit underrun sets its error bit
// - Write when full discarded, overrun bit set
// - Wire differs from driven level sets contention
// - Stuck high: no idle, end, go clear
// - Check sequence mismatch sets its error bit
// - Error bits read, reset zero, write-clear
// - Enable one gates error, end, begin
// - Enable two gates receive full, transmit empty
// - Negotiation pulse lasts period times setting/4
// - Bit rate is quarter of pulse rate
// - Core clock is system clock over divider
// - Fixed block identifier register
// - Fixed block revision register
// - Summary bit from any enabled status, irq also needs master enable
// - Error summary while any error bit set
// - Go set by software, cleared after end
`timescale 1ns/1ps
`default_nettype none
`include "tls_defs.vh"
module tls_link_status (
  input wire clk_sys,
  input wire resetn,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire ev_ready_loss,
  input wire ev_rx_overrun,
  input wire ev_tx_underrun,
  input wire ev_fcs_mismatch,
  input wire ev_frame_begin,
  input wire ev_frame_end,
  input wire ev_negotiate,
  input wire bus_idle_in,
  input wire rx_fifo_full_in,
  input wire rx_fifo_empty_in,
  input wire tx_fifo_empty_in,
  input wire tx_fifo_full_in,
  input wire tx_byte_wr,
  output wire tx_byte_accept,
  input wire core_drive_en,
  input wire core_drive_level,
  input wire wire_in,
  output wire wire_out,
  output wire wire_oe,
  output wire link_core_clock_en,
  output wire negotiate_busy,
  output wire transmit_go,
  output wire core_soft_reset,
  output wire irq
);
  // ****************************************************************
  // Registers and clears
  // ****************************************************************
  reg summary_irq_enable_ff;
  reg go_ff;
  reg srst_ff;
  reg eof_ff;
  reg bof_ff;
  reg [7:0] err_ff;
  reg [7:0] ien1_ff;
  reg [7:0] ien2_ff;
  reg [7:0] bt_lo_ff;
  reg [7:0] bt_hi_ff;
  reg [3:0] div_ff;
  reg stuck_ff;
  reg rff_ff;
  reg rfe_ff;
  reg wfe_ff;
  reg wff_ff;
  reg idle_ff;
  reg [7:0] nxt_err;
  reg [31:0] nxt_rdata;
  wire clr_n;
  wire wr_ctrl;
  wire wr_st1;
  wire wr_err;
  wire contention;
  wire [15:0] bt_val;
  wire sum_stat;
  wire err_any;
  wire drive_level;
  assign clr_n = resetn && !srst_ff;
  assign wr_ctrl = reg_wr && (reg_addr == `TLS_OFF_CTRL);
  assign wr_st1 = reg_wr && (reg_addr == `TLS_OFF_STAT1);
  assign wr_err = reg_wr && (reg_addr == `TLS_OFF_ERR);
  assign bt_val = {bt_hi_ff, bt_lo_ff};
  assign core_soft_reset = srst_ff;
  assign transmit_go = go_ff;

  // ****************************************************************
  // Core clock divider and negotiation pulse
  // ****************************************************************
  tls_clk_div u_div (
    .clk_sys(clk_sys),
    .clr_n(clr_n),
    .div_val(div_ff),
    .tick(link_core_clock_en)
  );

  tls_pulse_timer u_pulse (
    .clk_sys(clk_sys),
    .clr_n(clr_n),
    .start(ev_negotiate),
    .tick(link_core_clock_en),
    .ticks(bt_val[15:2]),
    .busy(negotiate_busy)
  );

  // ****************************************************************
  // Wire drive and contention check
  // ****************************************************************
  assign drive_level = negotiate_busy ? 1'b1 : core_drive_level;
  assign wire_out = drive_level;
  assign wire_oe = negotiate_busy || core_drive_en;
  assign contention = wire_oe && (wire_in != drive_level);

  // ****************************************************************
  // Transmit write guard
  // ****************************************************************
  assign tx_byte_accept = tx_byte_wr && !tx_fifo_full_in;

  // ****************************************************************
  // Control register
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (!resetn) begin
      srst_ff <= 1'b0;
    end else if (wr_ctrl) begin
      srst_ff <= reg_wdata[`TLS_CTRL_SRST];
    end
  end

  always @(posedge clk_sys) begin
    if (!clr_n) begin
      summary_irq_enable_ff <= 1'b0;
      go_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        summary_irq_enable_ff <= reg_wdata[`TLS_CTRL_SUMMARY_IRQ_ENABLE];
      end
      if (wr_ctrl && reg_wdata[`TLS_CTRL_GO]) begin
        go_ff <= 1'b1;
      end else if (ev_frame_end && !stuck_ff) begin
        go_ff <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Stuck wire fault and idle report
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (!clr_n) begin
      stuck_ff <= 1'b0;
      idle_ff <= 1'b1;
    end else begin
      if (go_ff && contention && drive_level == 1'b0) begin
        stuck_ff <= 1'b1;
      end
      idle_ff <= bus_idle_in && !stuck_ff;
    end
  end

  // ****************************************************************
  // FIFO flags
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (!clr_n) begin
      rff_ff <= 1'b0;
      rfe_ff <= 1'b1;
      wfe_ff <= 1'b1;
      wff_ff <= 1'b0;
    end else begin
      rff_ff <= rx_fifo_full_in;
      rfe_ff <= rx_fifo_empty_in;
      wfe_ff <= tx_fifo_empty_in;
      wff_ff <= tx_fifo_full_in;
    end
  end

  // ****************************************************************
  // Frame flags, write one to clear, set wins
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (!clr_n) begin
      eof_ff <= 1'b0;
      bof_ff <= 1'b0;
    end else begin
      if (ev_frame_end && !stuck_ff) begin
        eof_ff <= 1'b1;
      end else if (wr_st1 && reg_wdata[`TLS_ST1_EOF]) begin
        eof_ff <= 1'b0;
      end
      if (ev_frame_begin) begin
        bof_ff <= 1'b1;
      end else if (wr_st1 && reg_wdata[`TLS_ST1_BOF]) begin
        bof_ff <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Error capture
  // ****************************************************************
  always @* begin
    nxt_err = err_ff;
    if (wr_err) begin
      nxt_err = err_ff & ~reg_wdata[7:0];
    end
    if (ev_ready_loss) begin
      nxt_err[`TLS_ERR_READY] = 1'b1;
    end
    if (ev_rx_overrun) begin
      nxt_err[`TLS_ERR_RX_OVERRUN_ERROR] = 1'b1;
    end
    if (ev_tx_underrun) begin
      nxt_err[`TLS_ERR_TX_UNDERRUN_ERROR] = 1'b1;
    end
    if (tx_byte_wr && tx_fifo_full_in) begin
      nxt_err[`TLS_ERR_TX_OVERRUN_ERROR] = 1'b1;
    end
    if (contention) begin
      nxt_err[`TLS_ERR_CONT] = 1'b1;
    end
    if (ev_fcs_mismatch || ev_ready_loss) begin
      nxt_err[`TLS_ERR_FCS] = 1'b1;
    end
    nxt_err = nxt_err & `TLS_ERR_MASK;
  end

  always @(posedge clk_sys) begin
    if (!clr_n) begin
      err_ff <= 8'h00;
    end else begin
      err_ff <= nxt_err;
    end
  end

  assign err_any = |err_ff;

  // ****************************************************************
  // Enables, bit time and divider
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (!clr_n) begin
      ien1_ff <= 8'h00;
      ien2_ff <= 8'h00;
      bt_lo_ff <= `TLS_BT_LO_RST;
      bt_hi_ff <= `TLS_BT_HI_RST;
      div_ff <= `TLS_DIV_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `TLS_OFF_IEN1: begin
          ien1_ff <= reg_wdata[7:0] & `TLS_IEN1_MASK;
        end
        `TLS_OFF_IEN2: begin
          ien2_ff <= reg_wdata[7:0] & `TLS_IEN2_MASK;
        end
        `TLS_OFF_BT_LO: begin
          bt_lo_ff <= reg_wdata[7:0];
        end
        `TLS_OFF_BT_HI: begin
          bt_hi_ff <= reg_wdata[7:0];
        end
        `TLS_OFF_DIV: begin
          div_ff <= reg_wdata[3:0];
        end
        default: begin
          div_ff <= div_ff;
        end
      endcase
    end
  end

  // ****************************************************************
  // Summary status and interrupt
  // ****************************************************************
  assign sum_stat = (err_any && ien1_ff[`TLS_IEN1_ERR]) ||
                    (eof_ff && ien1_ff[`TLS_IEN1_EOF]) ||
                    (bof_ff && ien1_ff[`TLS_IEN1_BOF]) ||
                    (rff_ff && ien2_ff[`TLS_IEN2_RFF]) ||
                    (wfe_ff && ien2_ff[`TLS_IEN2_WFE]);
  assign irq = summary_irq_enable_ff && sum_stat;

  // ****************************************************************
  // Read data, one cycle after the strobe
  // ****************************************************************
  always @* begin
    nxt_rdata = 32'h00000000;
    case (reg_addr)
      `TLS_OFF_CTRL: begin
        nxt_rdata[`TLS_CTRL_SUMMARY_IRQ_ENABLE] = summary_irq_enable_ff;
        nxt_rdata[`TLS_CTRL_GO] = go_ff;
        nxt_rdata[`TLS_CTRL_SRST] = srst_ff;
      end
      `TLS_OFF_STAT1: begin
        nxt_rdata[`TLS_ST1_SUM] = sum_stat;
        nxt_rdata[`TLS_ST1_ERR] = err_any;
        nxt_rdata[`TLS_ST1_EOF] = eof_ff;
        nxt_rdata[`TLS_ST1_BOF] = bof_ff;
      end
      `TLS_OFF_STAT2: begin
        nxt_rdata[`TLS_ST2_IDLE] = idle_ff;
        nxt_rdata[`TLS_ST2_RFE] = rfe_ff;
        nxt_rdata[`TLS_ST2_RFF] = rff_ff;
        nxt_rdata[`TLS_ST2_WFE] = wfe_ff;
        nxt_rdata[`TLS_ST2_WFF] = wff_ff;
      end
      `TLS_OFF_ERR: begin
        nxt_rdata[7:0] = err_ff;
      end
      `TLS_OFF_IEN1: begin
        nxt_rdata[7:0] = ien1_ff;
      end
      `TLS_OFF_IEN2: begin
        nxt_rdata[7:0] = ien2_ff;
      end
      `TLS_OFF_BT_LO: begin
        nxt_rdata[7:0] = bt_lo_ff;
      end
      `TLS_OFF_BT_HI: begin
        nxt_rdata[7:0] = bt_hi_ff;
      end
      `TLS_OFF_DIV: begin
        nxt_rdata[3:0] = div_ff;
      end
      `TLS_OFF_ID: begin
        nxt_rdata = `TLS_ID_VAL;
      end
      `TLS_OFF_REV: begin
        nxt_rdata = `TLS_REV_VAL;
      end
      default: begin
        nxt_rdata = 32'h00000000;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (!resetn) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= nxt_rdata;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
endmodule // tls_link_status
`default_nettype wire

// ### tb/tls_client_model.sv
// Model of the thermal client at the far end of the data wire
// Assumes the host splits the wire into level, enable and sampled input
`timescale 1ns/1ps
`default_nettype none
module tls_client_model (
  input wire logic wire_out,
  input wire logic wire_oe,
  input wire logic client_pull,
  input wire logic stuck_high,
  output logic wire_in
);
  // Stuck fault wins, then client pull-down, then host drive
  always_comb begin
    if (stuck_high)
      wire_in = 1'b1;
    else if (wire_oe && !client_pull)
      wire_in = wire_out;
    else
      wire_in = 1'b0;
  end
endmodule // tls_client_model
`default_nettype wire

// ### tb/tls_link_status_sva.sv
// Checker on the ports of the thermal link status block
// Assumes logic/ on the include path and a bind to tls_link_status
`timescale 1ns/1ps
`default_nettype none
`include "tls_defs.vh"
module tls_link_status_sva (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic tx_byte_wr,
  input wire logic tx_fifo_full_in,
  input wire logic tx_byte_accept,
  input wire logic rx_fifo_full_in,
  input wire logic tx_fifo_empty_in,
  input wire logic ev_negotiate,
  input wire logic negotiate_busy,
  input wire logic wire_out,
  input wire logic wire_oe,
  input wire logic core_soft_reset,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  chk_accept_gate: assert property (
    tx_byte_accept == (tx_byte_wr && !tx_fifo_full_in))
    else $error("transmit accept wrong");
  chk_neg_drive: assert property (
    negotiate_busy |-> wire_oe && wire_out)
    else $error("negotiation pulse not driven high");
  chk_neg_start: assert property (
    ev_negotiate && !negotiate_busy && !core_soft_reset |=> negotiate_busy)
    else $error("negotiation did not start");
  chk_busy_cause: assert property (
    $rose(negotiate_busy) |-> $past(ev_negotiate))
    else $error("negotiation without request");
  chk_soft_irq: assert property (
    core_soft_reset [*2] |-> !irq)
    else $error("interrupt during soft reset");
  chk_id_read: assert property (
    $past(reg_rd) && $past(reg_addr) == 8'h40 |-> reg_rdata == `TLS_ID_VAL)
    else $error("identifier read wrong");
  chk_rev_read: assert property (
    $past(reg_rd) && $past(reg_addr) == 8'h44 |-> reg_rdata == `TLS_REV_VAL)
    else $error("revision read wrong");
  chk_err_rsvd: assert property (
    $past(reg_rd) && $past(reg_addr) == 8'h14 |-> reg_rdata[31:8] == 0
      && reg_rdata[3:2] == 2'h0)
    else $error("error reserved bits set");
  chk_en_rsvd: assert property (
    $past(reg_rd) && $past(reg_addr) inside {8'h18, 8'h1C}
      |-> reg_rdata[31:3] == 0 && !(reg_rdata[0] && $past(reg_addr[2])))
    else $error("enable reserved bits set");
  chk_fifo_flags: assert property (
    $past(reg_rd) && $past(reg_addr) == 8'h10 && $past(resetn, 2)
      |-> reg_rdata[2:0] == {$past(rx_fifo_full_in, 2),
      $past(tx_fifo_empty_in, 2), $past(tx_fifo_full_in, 2)})
    else $error("fifo flags wrong");
  cov_neg: cover property (ev_negotiate ##1 negotiate_busy);
  cov_srst: cover property (core_soft_reset);
  cov_irq: cover property ($rose(irq));
endmodule // tls_link_status_sva
bind tls_link_status tls_link_status_sva tls_link_status_sva_i (
  .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_byte_wr(tx_byte_wr),
  .tx_fifo_full_in(tx_fifo_full_in), .tx_byte_accept(tx_byte_accept),
  .rx_fifo_full_in(rx_fifo_full_in), .tx_fifo_empty_in(tx_fifo_empty_in),
  .ev_negotiate(ev_negotiate), .negotiate_busy(negotiate_busy),
  .wire_out(wire_out), .wire_oe(wire_oe),
  .core_soft_reset(core_soft_reset), .irq(irq));
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench of the thermal link status block
// Assumes logic/ on the include path
`timescale 1ns/1ps
`default_nettype none
`include "tls_defs.vh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  logic clk_sys = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 8'h00, b;
  logic [31:0] reg_wdata = 32'h0;
  wire [31:0] reg_rdata;
  logic [6:0] ev = 7'h00;
  logic idle = 1, rxf = 0, rxe = 1, txe = 1, txf = 0, twr = 0;
  logic den = 0, dlv = 0, pull = 0, stuck = 0;
  wire w_in, w_out, w_oe, tick, busy, go, srst, irq, acc;
  int errors = 0, n_compared = 0, seed = 32'h817E, i, d;
  tls_link_status tls_link_status_i (.clk_sys(clk_sys), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ev_ready_loss(ev[3]),
    .ev_rx_overrun(ev[2]), .ev_tx_underrun(ev[1]), .ev_fcs_mismatch(ev[0]),
    .ev_frame_begin(ev[4]), .ev_frame_end(ev[5]), .ev_negotiate(ev[6]),
    .bus_idle_in(idle), .rx_fifo_full_in(rxf), .rx_fifo_empty_in(rxe),
    .tx_fifo_empty_in(txe), .tx_fifo_full_in(txf), .tx_byte_wr(twr),
    .tx_byte_accept(acc), .core_drive_en(den), .core_drive_level(dlv),
    .wire_in(w_in), .wire_out(w_out), .wire_oe(w_oe),
    .link_core_clock_en(tick), .negotiate_busy(busy), .transmit_go(go),
    .core_soft_reset(srst), .irq(irq));
  tls_client_model tls_client_model_i (.wire_out(w_out), .wire_oe(w_oe),
    .client_pull(pull), .stuck_high(stuck), .wire_in(w_in));
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  function automatic [31:0] exp_err(input int k);
    exp_err = (k == 0) ? 32'h01 : (k == 3) ? 32'h81 : 32'h10 << k;
  endfunction
  task automatic wr(input [7:0] a, input [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 0;
  endtask
  task automatic rd_chk(input [7:0] a, input [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 0;
    @(negedge clk_sys);
    `CHK(reg_rdata, e)
  endtask
  task automatic pulse(input [6:0] m);
    @(posedge clk_sys);
    ev <= m;
    @(posedge clk_sys);
    ev <= 7'h00;
    @(negedge clk_sys);
  endtask
  task automatic irq_chk(input [7:0] a, input [31:0] v, input e);
    wr(a, v);
    @(negedge clk_sys);
    `CHK(irq, e)
  endtask
  task automatic neg_run(input [7:0] bt, input int dv);
    int c, t;
    c = 0;
    t = bt >> 2;
    wr(8'h20, {24'h0, bt});
    wr(8'h30, dv);
    pulse(7'h40);
    `CHK({w_oe, w_out}, 2'b11)
    while (busy && c < 9999) begin
      @(negedge clk_sys);
      c++;
    end
    `CHK((c > (t - 1) * dv) && (c <= t * dv + 1), 1'b1)
    c = 0;
    while (!tick) @(negedge clk_sys);
    @(negedge clk_sys);
    while (!tick && c < 99) begin
      @(negedge clk_sys);
      c++;
    end
    `CHK(c + 1, dv)
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    errors++;
    results;
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1;
    rd_chk(8'h14, 32'h0);
    rd_chk(8'h18, 32'h0);
    rd_chk(8'h1C, 32'h0);
    rd_chk(8'h20, 32'h16);
    rd_chk(8'h24, 32'h0);
    rd_chk(8'h30, 32'h1);
    rd_chk(8'h40, `TLS_ID_VAL);
    rd_chk(8'h44, `TLS_REV_VAL);
    rd_chk(8'h10, 32'h8A);
    rd_chk(8'h50, 32'h0);
    wr(8'h18, 32'hFFFFFFFF);
    rd_chk(8'h18, 32'h07);
    wr(8'h1C, 32'hFFFFFFFF);
    rd_chk(8'h1C, 32'h06);
    wr(8'h30, 32'hFFFFFFFF);
    rd_chk(8'h30, 32'h0F);
    wr(8'h40, 32'h0);
    rd_chk(8'h40, `TLS_ID_VAL);
    b = $random(seed);
    wr(8'h24, {24'h0, b});
    rd_chk(8'h24, {24'h0, b});
    wr(8'h24, 32'h0);
    wr(8'h18, 32'h0);
    wr(8'h1C, 32'h0);
    for (i = 0; i < 4; i++) begin
      pulse(7'h01 << i);
      rd_chk(8'h14, exp_err(i));
      rd_chk(8'h0C, 32'h04);
      wr(8'h14, 32'hFF);
      rd_chk(8'h14, 32'h0);
    end
    @(posedge clk_sys);
    twr <= 1;
    @(negedge clk_sys);
    `CHK(acc, 1'b1)
    @(posedge clk_sys);
    txf <= 1;
    @(negedge clk_sys);
    `CHK(acc, 1'b0)
    @(posedge clk_sys);
    twr <= 0;
    txf <= 0;
    rd_chk(8'h14, 32'h10);
    @(posedge clk_sys);
    den <= 1;
    dlv <= 1;
    pull <= 1;
    @(posedge clk_sys);
    den <= 0;
    pull <= 0;
    rd_chk(8'h14, 32'h12);
    wr(8'h14, 32'hFF);
    wr(8'h08, 32'h80);
    pulse(7'h04);
    irq_chk(8'h18, 32'h04, 1'b1);
    rd_chk(8'h0C, 32'h84);
    irq_chk(8'h18, 32'h0, 1'b0);
    wr(8'h14, 32'hFF);
    pulse(7'h10);
    irq_chk(8'h18, 32'h01, 1'b1);
    irq_chk(8'h0C, 32'h01, 1'b0);
    pulse(7'h20);
    irq_chk(8'h18, 32'h02, 1'b1);
    irq_chk(8'h0C, 32'h02, 1'b0);
    @(posedge clk_sys);
    rxf <= 1;
    txe <= 0;
    txf <= 1;
    irq_chk(8'h1C, 32'h04, 1'b1);
    @(posedge clk_sys);
    rxf <= 0;
    irq_chk(8'h1C, 32'h06, 1'b0);
    @(posedge clk_sys);
    txe <= 1;
    txf <= 0;
    irq_chk(8'h1C, 32'h02, 1'b1);
    irq_chk(8'h08, 32'h0, 1'b0);
    wr(8'h1C, 32'h0);
    neg_run(8'h10, 1);
    for (i = 0; i < 3; i++) begin
      d = 1 + {$random(seed)} % 3;
      neg_run(8'h10 + {$random(seed)} % 240, d);
    end
    @(posedge clk_sys);
    idle <= 0;
    rxe <= 0;
    rd_chk(8'h10, 32'h02);
    @(posedge clk_sys);
    idle <= 1;
    rxe <= 1;
    rd_chk(8'h10, 32'h8A);
    wr(8'h08, 32'h40);
    @(negedge clk_sys);
    `CHK(go, 1'b1)
    pulse(7'h20);
    `CHK(go, 1'b0)
    wr(8'h0C, 32'h02);
    wr(8'h08, 32'h40);
    den <= 1;
    dlv <= 0;
    stuck <= 1;
    pulse(7'h20);
    `CHK(go, 1'b1)
    rd_chk(8'h10, 32'h0A);
    rd_chk(8'h14, 32'h02);
    rd_chk(8'h0C, 32'h04);
    @(posedge clk_sys);
    den <= 0;
    stuck <= 0;
    wr(8'h08, 32'h08);
    @(negedge clk_sys);
    `CHK(srst, 1'b1)
    wr(8'h08, 32'h0);
    `CHK(go, 1'b0)
    rd_chk(8'h10, 32'h8A);
    rd_chk(8'h14, 32'h0);
    results;
  end
endmodule // testbench
`default_nettype wire
